// ==== pkg/lcc_regs.svh ====
// register offsets, field positions and reset values of the lane slice
`ifndef LCC_REGS_SVH
`define LCC_REGS_SVH

`define LCC_ADDR_A0_IDLE       8'h2B
`define LCC_ADDR_EQ            8'h2C
`define LCC_ADDR_SWING_FIRST   8'h2D
`define LCC_ADDR_SWING_SECOND  8'h2E
`define LCC_ADDR_IDLE_THRESH   8'h2F
`define LCC_ADDR_B0_IDLE       8'h32

`define LCC_RST_A0_IDLE        8'h00
`define LCC_RST_EQ             8'h20
`define LCC_RST_SWING_FIRST    8'h03
`define LCC_RST_SWING_SECOND   8'h03
`define LCC_RST_IDLE_THRESH    8'h00
`define LCC_RST_B0_IDLE        8'h00

`define LCC_BIT_IDLE_AUTO      5
`define LCC_BIT_IDLE_SEL       4
`define LCC_BIT_EQ_EN          5
`define LCC_FLD_GAIN_HI        4
`define LCC_FLD_GAIN_LO        3
`define LCC_FLD_BOOST_HI       2
`define LCC_FLD_BOOST_LO       0
`define LCC_FLD_SWING_HI       6
`define LCC_FLD_DEASSERT_HI    3
`define LCC_FLD_DEASSERT_LO    2
`define LCC_FLD_ASSERT_HI      1
`define LCC_FLD_ASSERT_LO      0

`define LCC_EQ_CODE_LOW_BOOST  8'h2A
`define LCC_EQ_CODE_MID_BOOST  8'h39
`define LCC_SWING_CODE_600MV   8'h03
`define LCC_SWING_CODE_800MV   8'h07
`define LCC_SWING_CODE_1000MV  8'h0F

`endif

// ==== pkg/lcc_pkg.sv ====
// types shared by the lane conditioning register bank
package lcc_pkg;

    typedef enum logic [1:0] {
        LCC_IDLE_DRIVE,
        LCC_IDLE_MUTE,
        LCC_IDLE_AUTO
    } lcc_idle_mode_type;

    typedef logic [7:0] lcc_byte_type;

endpackage : lcc_pkg

// ==== hdl/lcc_config_regs.sv ====
// lane 0 conditioning configuration registers and idle control
//
// Behaviour
// - auto idle bit mutes via own detection
// - manual: select 0 drives, 1 mutes
// - equalizer field: enable, gain, boost
// - equalizer resets to bypass code 20h
// - 32 settings: four gains, eight boosts
// - swing field selects amplitude, reset 03h
// - second swing register, eight bits, reset 03h
// - threshold: deassert bits 3:2, assert 1:0
`timescale 1ns/100ps
`default_nettype none
`include "lcc_regs.svh"

module lcc_config_regs (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       lane0_elec_idle,
    output logic            output_a_lane0_mute,
    output logic            output_a_lane0_signal_detect_en,
    output logic            output_b_lane0_mute,
    output logic            output_b_lane0_signal_detect_en,
    output logic            equalizer_setting_en,
    output logic      [1:0] gain_stage_select,
    output logic      [2:0] boost_level_select,
    output logic      [6:0] output_swing_first,
    output logic      [7:0] output_swing_second,
    output logic      [1:0] idle_deassert_level,
    output logic      [1:0] idle_assert_level
);

    lcc_pkg::lcc_byte_type a0_idle_r, a0_idle_nxt;
    lcc_pkg::lcc_byte_type eq_r, eq_nxt;
    lcc_pkg::lcc_byte_type swing1_r, swing1_nxt;
    lcc_pkg::lcc_byte_type swing2_r, swing2_nxt;
    lcc_pkg::lcc_byte_type thresh_r, thresh_nxt;
    lcc_pkg::lcc_byte_type b0_idle_r, b0_idle_nxt;
    lcc_pkg::lcc_byte_type rdata_r, rdata_nxt;
    logic                  idle_meta_r;
    logic                  idle_sync_r;
    logic                  a_mute_r, a_mute_nxt;
    logic                  b_mute_r, b_mute_nxt;

    // decode an idle control byte into its mode
    function automatic lcc_pkg::lcc_idle_mode_type idle_mode(
        input lcc_pkg::lcc_byte_type ctrl
    );
        lcc_pkg::lcc_idle_mode_type m;
        if (ctrl[`LCC_BIT_IDLE_AUTO]) begin
            m = lcc_pkg::LCC_IDLE_AUTO;
        end else if (ctrl[`LCC_BIT_IDLE_SEL]) begin
            m = lcc_pkg::LCC_IDLE_MUTE;
        end else begin
            m = lcc_pkg::LCC_IDLE_DRIVE;
        end
        return m;
    endfunction : idle_mode

    // mute decision for one output
    function automatic logic mute_for(
        input lcc_pkg::lcc_byte_type ctrl,
        input logic                  idle
    );
        logic r;
        case (idle_mode(ctrl))
            lcc_pkg::LCC_IDLE_AUTO:  r = idle;
            lcc_pkg::LCC_IDLE_MUTE:  r = 1'b1;
            lcc_pkg::LCC_IDLE_DRIVE: r = 1'b0;
            default:                 r = 1'b0;
        endcase
        return r;
    endfunction : mute_for

    // register writes and reads
    always_comb begin
        a0_idle_nxt = a0_idle_r;
        eq_nxt      = eq_r;
        swing1_nxt  = swing1_r;
        swing2_nxt  = swing2_r;
        thresh_nxt  = thresh_r;
        b0_idle_nxt = b0_idle_r;
        rdata_nxt   = rdata_r;
        if (reg_wr) begin
            case (reg_addr)
                `LCC_ADDR_A0_IDLE:      a0_idle_nxt = reg_wdata;
                `LCC_ADDR_EQ:           eq_nxt      = reg_wdata;
                `LCC_ADDR_SWING_FIRST:  swing1_nxt  = reg_wdata;
                `LCC_ADDR_SWING_SECOND: swing2_nxt  = reg_wdata;
                `LCC_ADDR_IDLE_THRESH:  thresh_nxt  = reg_wdata;
                `LCC_ADDR_B0_IDLE:      b0_idle_nxt = reg_wdata;
                default:                a0_idle_nxt = a0_idle_r;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                `LCC_ADDR_A0_IDLE:      rdata_nxt = a0_idle_r;
                `LCC_ADDR_EQ:           rdata_nxt = eq_r;
                `LCC_ADDR_SWING_FIRST:  rdata_nxt = swing1_r;
                `LCC_ADDR_SWING_SECOND: rdata_nxt = swing2_r;
                `LCC_ADDR_IDLE_THRESH:  rdata_nxt = thresh_r;
                `LCC_ADDR_B0_IDLE:      rdata_nxt = b0_idle_r;
                default:                rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            a0_idle_r <= `LCC_RST_A0_IDLE;
            eq_r      <= `LCC_RST_EQ;
            swing1_r  <= `LCC_RST_SWING_FIRST;
            swing2_r  <= `LCC_RST_SWING_SECOND;
            thresh_r  <= `LCC_RST_IDLE_THRESH;
            b0_idle_r <= `LCC_RST_B0_IDLE;
            rdata_r   <= 8'h00;
        end else begin
            a0_idle_r <= a0_idle_nxt;
            eq_r      <= eq_nxt;
            swing1_r  <= swing1_nxt;
            swing2_r  <= swing2_nxt;
            thresh_r  <= thresh_nxt;
            b0_idle_r <= b0_idle_nxt;
            rdata_r   <= rdata_nxt;
        end
    end

    // idle detector is analog, hence two flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            idle_meta_r <= 1'b0;
            idle_sync_r <= 1'b0;
        end else begin
            idle_meta_r <= lane0_elec_idle;
            idle_sync_r <= idle_meta_r;
        end
    end

    // mute from next control byte, so it lands with the write
    always_comb begin
        a_mute_nxt = mute_for(a0_idle_nxt, idle_sync_r);
        b_mute_nxt = mute_for(b0_idle_nxt, idle_sync_r);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            a_mute_r <= 1'b0;
            b_mute_r <= 1'b0;
        end else begin
            a_mute_r <= a_mute_nxt;
            b_mute_r <= b_mute_nxt;
        end
    end

    // analog controls follow stored fields
    assign reg_rdata                       = rdata_r;
    assign output_a_lane0_mute             = a_mute_r;
    assign output_b_lane0_mute             = b_mute_r;
    assign output_a_lane0_signal_detect_en = a0_idle_r[`LCC_BIT_IDLE_AUTO];
    assign output_b_lane0_signal_detect_en = b0_idle_r[`LCC_BIT_IDLE_AUTO];
    assign equalizer_setting_en = eq_r[`LCC_BIT_EQ_EN];
    assign gain_stage_select =
        eq_r[`LCC_FLD_GAIN_HI:`LCC_FLD_GAIN_LO];
    assign boost_level_select =
        eq_r[`LCC_FLD_BOOST_HI:`LCC_FLD_BOOST_LO];
    assign output_swing_first  = swing1_r[`LCC_FLD_SWING_HI:0];
    assign output_swing_second = swing2_r;
    assign idle_deassert_level =
        thresh_r[`LCC_FLD_DEASSERT_HI:`LCC_FLD_DEASSERT_LO];
    assign idle_assert_level =
        thresh_r[`LCC_FLD_ASSERT_HI:`LCC_FLD_ASSERT_LO];

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    AST_AUTO_MUTE_FOLLOWS: assert property (
        a0_idle_r[`LCC_BIT_IDLE_AUTO] && idle_sync_r
        ##1 a0_idle_r[`LCC_BIT_IDLE_AUTO]
        |-> output_a_lane0_mute)
        else $error("auto idle did not mute output a");

    AST_MANUAL_DRIVE: assert property (
        (a0_idle_r[5:4] == 2'b00) |-> !output_a_lane0_mute)
        else $error("manual drive left output a muted");

    AST_MANUAL_FORCE_MUTE: assert property (
        (b0_idle_r[5:4] == 2'b01) && !reg_wr |=> output_b_lane0_mute)
        else $error("manual mute did not mute output b");

    AST_EQ_FIELDS: assert property (
        reg_wr && reg_addr == `LCC_ADDR_EQ
        |=> equalizer_setting_en == $past(reg_wdata[5])
            && gain_stage_select == $past(reg_wdata[4:3])
            && boost_level_select == $past(reg_wdata[2:0]))
        else $error("equalizer fields not decoded from write");

    AST_EQ_RESET_BYPASS: assert property (
        $past(!rst_n) |-> eq_r == `LCC_RST_EQ
            && swing1_r == `LCC_RST_SWING_FIRST)
        else $error("reset values wrong after release");

    AST_SWING_FIRST: assert property (
        reg_wr && reg_addr == `LCC_ADDR_SWING_FIRST
        |=> output_swing_first == $past(reg_wdata[6:0]))
        else $error("swing field not taken from write");

    AST_SWING_SECOND_RB: assert property (
        reg_wr && reg_addr == `LCC_ADDR_SWING_SECOND ##1 reg_rd
        && reg_addr == `LCC_ADDR_SWING_SECOND && !reg_wr
        |=> reg_rdata == $past(reg_wdata, 2))
        else $error("second swing register read back wrong");

    AST_THRESH_FIELDS: assert property (
        reg_wr && reg_addr == `LCC_ADDR_IDLE_THRESH
        |=> idle_deassert_level == $past(reg_wdata[3:2])
            && idle_assert_level == $past(reg_wdata[1:0]))
        else $error("threshold fields not taken from write");

    AST_UNMAPPED_ZERO: assert property (
        reg_rd && reg_addr == 8'h30 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");

    AST_HOLD_NO_WRITE: assert property (
        !reg_wr |=> $stable(eq_r) && $stable(swing2_r) && $stable(thresh_r))
        else $error("control changed without write");

    AST_MANUAL_FORCE_MUTE_A: assert property (
        (a0_idle_r[5:4] == 2'b01) |-> output_a_lane0_mute)
        else $error("manual mute did not mute output a");

    AST_MANUAL_DRIVE_B: assert property (
        (b0_idle_r[5:4] == 2'b00) |-> !output_b_lane0_mute)
        else $error("manual drive left output b muted");

    AST_AUTO_MUTE_FOLLOWS_B: assert property (
        b0_idle_r[`LCC_BIT_IDLE_AUTO] && idle_sync_r
        ##1 b0_idle_r[`LCC_BIT_IDLE_AUTO]
        |-> output_b_lane0_mute)
        else $error("auto idle did not mute output b");

    AST_AUTO_UNMUTE: assert property (
        a0_idle_r[`LCC_BIT_IDLE_AUTO] && !idle_sync_r
        ##1 a0_idle_r[`LCC_BIT_IDLE_AUTO]
        |-> !output_a_lane0_mute)
        else $error("auto idle kept output a muted");

    AST_A0_WRITE_LANDS: assert property (
        reg_wr && reg_addr == `LCC_ADDR_A0_IDLE
        |=> output_a_lane0_signal_detect_en == $past(reg_wdata[5])
            && ($past(reg_wdata[5])
                || output_a_lane0_mute == $past(reg_wdata[4])))
        else $error("idle control write did not take effect on a");

    AST_B0_WRITE_LANDS: assert property (
        reg_wr && reg_addr == `LCC_ADDR_B0_IDLE
        |=> output_b_lane0_signal_detect_en == $past(reg_wdata[5])
            && ($past(reg_wdata[5])
                || output_b_lane0_mute == $past(reg_wdata[4])))
        else $error("idle control write did not take effect on b");

    AST_SWING_SECOND: assert property (
        reg_wr && reg_addr == `LCC_ADDR_SWING_SECOND
        |=> output_swing_second == $past(reg_wdata))
        else $error("second swing field not taken from write");

    AST_UNMAPPED_WRITE_IGNORED: assert property (
        reg_wr && reg_addr == 8'h30
        |=> $stable(a0_idle_r) && $stable(eq_r) && $stable(swing1_r)
            && $stable(swing2_r) && $stable(thresh_r)
            && $stable(b0_idle_r))
        else $error("unmapped write changed a register");

    AST_READ_HOLDS: assert property (
        !reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");

    AST_RESET_OTHERS: assert property (
        $past(!rst_n) |-> swing2_r == `LCC_RST_SWING_SECOND
            && thresh_r == `LCC_RST_IDLE_THRESH
            && a0_idle_r == `LCC_RST_A0_IDLE
            && b0_idle_r == `LCC_RST_B0_IDLE)
        else $error("reset values wrong after release");

    COV_EQ_LOW_BOOST: cover property (
        reg_wr && reg_addr == `LCC_ADDR_EQ
        && reg_wdata == `LCC_EQ_CODE_LOW_BOOST);
    COV_EQ_MID_BOOST: cover property (
        reg_wr && reg_addr == `LCC_ADDR_EQ
        && reg_wdata == `LCC_EQ_CODE_MID_BOOST);
    COV_SWING_1000: cover property (
        output_swing_first == `LCC_SWING_CODE_1000MV);
    COV_AUTO_MUTE: cover property (
        a0_idle_r[`LCC_BIT_IDLE_AUTO] ##1 output_a_lane0_mute);
    COV_MANUAL_MUTE_B: cover property (
        b0_idle_r[5:4] == 2'b01 ##1 output_b_lane0_mute);

endmodule : lcc_config_regs
`default_nettype wire

// ==== testbench/lcc_config_regs_tb_top.sv ====
// self-checking bench for the lane conditioning register bank
`timescale 1ns/100ps
`default_nettype none
`include "lcc_regs.svh"

module lcc_config_regs_tb_top;
    logic       clk;
    logic       rst_n;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic       lane0_elec_idle;
    logic       a_mute;
    logic       a_sd;
    logic       b_mute;
    logic       b_sd;
    logic       eq_en;
    logic [1:0] gain;
    logic [2:0] boost;
    logic [6:0] swing1;
    logic [7:0] swing2;
    logic [1:0] deassert_lvl;
    logic [1:0] assert_lvl;
    logic [7:0] ad;
    int         bad_count;
    int         n_tests;
    int         cyc;
    logic [7:0] addrs [6] = '{`LCC_ADDR_A0_IDLE, `LCC_ADDR_EQ,
        `LCC_ADDR_SWING_FIRST, `LCC_ADDR_SWING_SECOND,
        `LCC_ADDR_IDLE_THRESH, `LCC_ADDR_B0_IDLE};
    logic [7:0] rstv [6] = '{8'h00, 8'h20, 8'h03, 8'h03, 8'h00, 8'h00};
    logic [7:0] eqc [3] = '{8'h2A, 8'h39, 8'h3D};
    logic [7:0] swc [3] = '{8'h07, 8'h0F, 8'h03};

    lcc_config_regs dut (
        .clk                             (clk),
        .rst_n                           (rst_n),
        .reg_addr                        (reg_addr),
        .reg_wdata                       (reg_wdata),
        .reg_wr                          (reg_wr),
        .reg_rd                          (reg_rd),
        .reg_rdata                       (reg_rdata),
        .lane0_elec_idle                 (lane0_elec_idle),
        .output_a_lane0_mute             (a_mute),
        .output_a_lane0_signal_detect_en (a_sd),
        .output_b_lane0_mute             (b_mute),
        .output_b_lane0_signal_detect_en (b_sd),
        .equalizer_setting_en            (eq_en),
        .gain_stage_select               (gain),
        .boost_level_select              (boost),
        .output_swing_first              (swing1),
        .output_swing_second             (swing2),
        .idle_deassert_level             (deassert_lvl),
        .idle_assert_level               (assert_lvl)
    );

    always #5 clk = ~clk;

    task automatic chk(input string name, input logic [7:0] exp,
                       input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge clk);
        reg_wr    = 1'b0;
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge clk);
        reg_rd   = 1'b0;
        chk("rdata", exp, reg_rdata);
    endtask : rd_chk

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : final_report

    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            final_report();
        end
    end

    initial begin
        clk = 1'b0; rst_n = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
        reg_wr = 1'b0; reg_rd = 1'b0; lane0_elec_idle = 1'b0;
        bad_count = 0; n_tests = 0; cyc = 0;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        chk("eq_fields", 8'h20, {2'b00, eq_en, gain, boost});
        chk("swing1", 8'h03, 8'(swing1));
        chk("swing2", 8'h03, swing2);
        chk("levels", 8'h00, {4'h0, deassert_lvl, assert_lvl});
        chk("mutes", 8'h00, {4'h0, a_mute, a_sd, b_mute, b_sd});
        for (int i = 0; i < 6; i++) rd_chk(addrs[i], rstv[i]);
        foreach (eqc[i]) begin
            wr(`LCC_ADDR_EQ, eqc[i]);
            chk("eq_en", 8'(eqc[i][5]), 8'(eq_en));
            chk("gain", 8'(eqc[i][4:3]), 8'(gain));
            chk("boost", 8'(eqc[i][2:0]), 8'(boost));
            rd_chk(`LCC_ADDR_EQ, eqc[i]);
        end
        foreach (swc[i]) begin
            wr(`LCC_ADDR_SWING_FIRST, swc[i]);
            chk("swing1", swc[i], 8'(swing1));
        end
        wr(`LCC_ADDR_SWING_FIRST, 8'h3F);
        chk("swing1", 8'h3F, 8'(swing1));
        rd_chk(`LCC_ADDR_SWING_FIRST, 8'h3F);
        wr(`LCC_ADDR_SWING_SECOND, 8'hA5);
        chk("swing2", 8'hA5, swing2);
        rd_chk(`LCC_ADDR_SWING_SECOND, 8'hA5);
        // write then read in the very next cycle
        @(negedge clk);
        reg_addr = `LCC_ADDR_SWING_SECOND;
        reg_wdata = 8'h5C;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        chk("swing2", 8'h5C, swing2);
        chk("rdata", 8'h5C, reg_rdata);
        // write and read together return the old value
        @(negedge clk);
        reg_addr = `LCC_ADDR_IDLE_THRESH; reg_wdata = 8'h0B;
        reg_wr = 1'b1; reg_rd = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0; reg_rd = 1'b0;
        chk("rdata", 8'h00, reg_rdata);
        chk("levels", 8'h0B, {4'h0, deassert_lvl, assert_lvl});
        rd_chk(`LCC_ADDR_IDLE_THRESH, 8'h0B);
        wr(8'h30, 8'h5A);
        rd_chk(8'h30, 8'h00);
        for (int j = 0; j < 2; j++) begin
            ad = (j == 1) ? `LCC_ADDR_B0_IDLE : `LCC_ADDR_A0_IDLE;
            wr(ad, 8'h10);
            chk("mute", 8'h01, 8'(j == 1 ? b_mute : a_mute));
            chk("sd_en", 8'h00, 8'(j == 1 ? b_sd : a_sd));
            wr(ad, 8'h00);
            chk("mute", 8'h00, 8'(j == 1 ? b_mute : a_mute));
            wr(ad, 8'h20);
            chk("sd_en", 8'h01, 8'(j == 1 ? b_sd : a_sd));
            lane0_elec_idle = 1'b1;
            repeat (3) @(negedge clk);
            chk("mute", 8'h01, 8'(j == 1 ? b_mute : a_mute));
            chk("other", 8'h00, 8'(j == 1 ? a_mute : b_mute));
            lane0_elec_idle = 1'b0;
            repeat (3) @(negedge clk);
            chk("mute", 8'h00, 8'(j == 1 ? b_mute : a_mute));
            rd_chk(ad, 8'h20);
            wr(ad, 8'h00);
        end
        final_report();
    end
endmodule : lcc_config_regs_tb_top
`default_nettype wire
